//--- rtl/i2cs_consts.vh
// Constants of the two-wire target engine: offsets, fields, resets, timing
// Behaviour
// - Byte moved on bus sets byte-done flag
// - Received byte answered per reply-action setting
// - Hold SCL low after a received byte until byte-done serviced
// - Refused send sets flag, releases SDA
// - STOP sets stop flag if addressed, returns to idle
// - Rate 0x2 plus stretch-mode enables automatic speed switch
// - Refused controller code enters fast mode till STOP
// - Wide addressing: ack first byte, flag second
// - Wide read: repeated header flags read direction
// - Group order: stop flag only if addressed
// - Group order off: unaddressed STOP sets nothing
// - Own flags; mask-set enables, mask-clear disables
// - Request while flag set and source enabled
// - Controller: core clock runs idle, standby if kept
// - Controller standby: clock stops after transaction ends
// - Kept alive: address match wakes from standby
// - Not kept alive: standby receptions discarded
// - Reset, enable, command, line-state writes synchronised
`ifndef I2CS_CONSTS_VH
`define I2CS_CONSTS_VH

// ********************
// Register offsets
// ********************
`define I2CS_A_CTRL1 8'h00
`define I2CS_A_CTRL2 8'h04
`define I2CS_A_MCLR 8'h08
`define I2CS_A_MSET 8'h0C
`define I2CS_A_FLAG 8'h10
`define I2CS_A_STAT 8'h14
`define I2CS_A_ADDR 8'h18
`define I2CS_A_DATA 8'h1C

// ********************
// Field positions
// ********************
`define I2CS_C1_SOFT_RESET_BIT 0
`define I2CS_C1_EN 1
`define I2CS_C1_KEEP 2
`define I2CS_C1_SPD 3
`define I2CS_C1_STRETCH_MODE_SEL 5
`define I2CS_C1_CTRLM 6
`define I2CS_C2_ACT 0
`define I2CS_C2_GROUP_ORDER_EN 1
`define I2CS_C2_CMD 2
`define I2CS_F_STOP 0
`define I2CS_F_AMATCH 1
`define I2CS_F_DONE 2
`define I2CS_ST_NACK 0
`define I2CS_ST_DIR 1
`define I2CS_ST_HS 2
`define I2CS_ST_TACT 3
`define I2CS_ST_SYNC 4
`define I2CS_ST_BUS 5
`define I2CS_AD_TEN 15

// ********************
// Values and timing
// ********************
`define I2CS_SPD_HS 2'h2
`define I2CS_CMD_ABORT 2'h2
`define I2CS_CMD_SERVICE 2'h3
`define I2CS_SYNC_CYC 2'h3
`define I2CS_RST_ADDR 16'h0000
`define I2CS_HDR10 5'h1E
`define I2CS_MCODE 5'h01

`endif

//--- rtl/i2cs_top.v
// Two-wire bus target engine with classic Wishbone register access
`timescale 1ns/1ns
`default_nettype none
`include "i2cs_consts.vh"
module i2cs_top (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire scl_i,
   output reg scl_o,
   output reg scl_oe_o,
   input wire sda_i,
   output reg sda_o,
   output reg sda_oe_o,
   input wire standby_i,
   output reg irq_o,
   output reg wake_o,
   output reg core_clk_run_o
);

// ********************
// Protocol states
// ********************
localparam [3:0] S_IDLE = 4'h0;
localparam [3:0] S_ADDR = 4'h1;
localparam [3:0] S_AACK = 4'h2;
localparam [3:0] S_ADDR2 = 4'h3;
localparam [3:0] S_RX = 4'h4;
localparam [3:0] S_RXW = 4'h5;
localparam [3:0] S_RACK = 4'h6;
localparam [3:0] S_TX = 4'h7;
localparam [3:0] S_TACK = 4'h8;
localparam [3:0] S_TLD = 4'h9;
localparam [3:0] S_SKIP = 4'hA;

// Byte-lane merge of a write into an old value
function [31:0] lane_merge;
   input [31:0] old;
   input [31:0] nw;
   input [3:0] sel;
   integer i;
   begin
      lane_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
         if (sel[i]) begin
            lane_merge[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
   end
endfunction

// ********************
// Register state
// ********************
reg keep; // Keep core clock alive in standby
reg [1:0] spd; // Rate select
reg stretch_mode_sel; // Stretch-mode select
reg ctrlm; // Controller operation select
reg en_sh; // Enable as written, read back at once
reg en; // Enable as seen by the engine
reg reply_action; // Ack or refusal after a received byte
reg group_order_en; // Group command mode
reg [1:0] line_state; // Line-state field
reg [2:0] mask; // Interrupt enables
reg [15:0] addr_reg; // Own address and wide_addr_en
reg [7:0] txd; // Next byte to send
reg [7:0] rxd; // Last byte received
reg [2:0] flags; // Sticky interrupt flags
reg refused_byte_flag; // Last sent byte refused
reg dir; // Read-not-write of current transfer
reg fast_mode_flag; // High-speed mode active
reg target_active_flag; // Addressed in this transfer
// Pending writes for the synchroniser
reg [1:0] sync_cnt;
reg p_soft_reset_bit;
reg p_en;
reg p_cmd_v;
reg [1:0] p_cmd;
reg p_bus_v;
reg [1:0] p_bus;
reg soft_reset_bit_now; // One-cycle soft reset
reg svc_now; // One-cycle service command
reg abort_now; // One-cycle abort command

// Protocol engine state
reg [3:0] state;
reg [3:0] nxt; // State after the address ack
reg [3:0] bitn;
reg [7:0] sh;
reg ten_ok; // Wide address matched since STOP
reg addressed; // Matched since STOP, or since START outside group mode
reg ev_stop;
reg ev_amatch;
reg ev_done;
reg ev_nack;

// ********************
// Pin synchronisers
// ********************
reg scl_s1, scl_s2, scl_s3;
reg sda_s1, sda_s2, sda_s3;

// Two flops each, third stage only for edge finding
always @(posedge clk_i) begin
   scl_s1 <= scl_i;
   scl_s2 <= scl_s1;
   scl_s3 <= scl_s2;
   sda_s1 <= sda_i;
   sda_s2 <= sda_s1;
   sda_s3 <= sda_s2;
end

wire rise = scl_s2 & ~scl_s3;
wire fall = ~scl_s2 & scl_s3;
wire start_c = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
wire stop_c = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
wire wide = addr_reg[`I2CS_AD_TEN];
// Not kept alive: standby blocks every address match
wire awake = ~(standby_i & ~keep);
wire srst = rst_i | soft_reset_bit_now;

// ********************
// Bus decode
// ********************
wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wr = req & wb_we_i;
wire rd = req & ~wb_we_i;
wire [31:0] wm = lane_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
// Address write merged on lanes, upper half dropped on purpose below
wire [31:0] addr_wr = lane_merge({16'h0000, addr_reg}, wb_dat_i, wb_sel_i);
wire data_hit = req & (wb_adr_i == `I2CS_A_DATA);
wire [31:0] c1_rd = {25'h0, ctrlm, stretch_mode_sel, spd, keep, en_sh, p_soft_reset_bit};
wire [31:0] c2_rd = {28'h0, p_cmd, group_order_en, reply_action};
wire [31:0] st_rd = {25'h0, line_state, (sync_cnt != 2'h0),
   target_active_flag, fast_mode_flag, dir, refused_byte_flag};
reg [31:0] rmux;

// Read multiplexer, unmapped reads give zero
always @* begin
   case (wb_adr_i)
      `I2CS_A_CTRL1: rmux = c1_rd;
      `I2CS_A_CTRL2: rmux = c2_rd;
      `I2CS_A_MCLR: rmux = {29'h0, mask};
      `I2CS_A_MSET: rmux = {29'h0, mask};
      `I2CS_A_FLAG: rmux = {29'h0, flags};
      `I2CS_A_STAT: rmux = st_rd;
      `I2CS_A_ADDR: rmux = {16'h0, addr_reg};
      `I2CS_A_DATA: rmux = {24'h0, rxd};
      default: rmux = 32'h0000_0000;
   endcase
end

// Answer every request one cycle after it is seen
always @(posedge clk_i) begin
   if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
   end else begin
      wb_ack_o <= req;
      if (rd) begin
         wb_dat_o <= rmux;
      end
   end
end

// ********************
// Registers and write synchronisation
// ********************
// Critical fields pass a short pipeline before taking effect
always @(posedge clk_i) begin
   if (srst) begin
      {keep, spd, stretch_mode_sel, ctrlm, en_sh, en} <= 7'h00;
      {reply_action, group_order_en, line_state} <= 4'h0;
      mask <= 3'h0;
      addr_reg <= `I2CS_RST_ADDR;
      txd <= 8'h00;
      sync_cnt <= 2'h0;
      {p_soft_reset_bit, p_en, p_cmd_v, p_bus_v} <= 4'h0;
      p_cmd <= 2'h0;
      p_bus <= 2'h0;
      {soft_reset_bit_now, svc_now, abort_now} <= 3'h0;
   end else begin
      soft_reset_bit_now <= 1'b0;
      svc_now <= 1'b0;
      abort_now <= 1'b0;
      if (sync_cnt == 2'h1) begin
         soft_reset_bit_now <= p_soft_reset_bit;
         en <= p_en;
         svc_now <= p_cmd_v & (p_cmd == `I2CS_CMD_SERVICE);
         abort_now <= p_cmd_v & (p_cmd == `I2CS_CMD_ABORT);
         if (p_bus_v) begin
            line_state <= p_bus;
         end
         p_cmd_v <= 1'b0;
         p_bus_v <= 1'b0;
      end
      if (sync_cnt != 2'h0) begin
         sync_cnt <= sync_cnt - 2'h1;
      end
      if (wr && wb_sel_i[0]) begin
         case (wb_adr_i)
            `I2CS_A_CTRL1: begin
               // Soft reset wins over the rest of the write
               if (wb_dat_i[`I2CS_C1_SOFT_RESET_BIT]) begin
                  p_soft_reset_bit <= 1'b1;
               end else begin
                  en_sh <= wb_dat_i[`I2CS_C1_EN];
                  p_en <= wb_dat_i[`I2CS_C1_EN];
                  keep <= wb_dat_i[`I2CS_C1_KEEP];
                  spd <= wb_dat_i[`I2CS_C1_SPD +: 2];
                  stretch_mode_sel <= wb_dat_i[`I2CS_C1_STRETCH_MODE_SEL];
                  ctrlm <= wb_dat_i[`I2CS_C1_CTRLM];
               end
               sync_cnt <= `I2CS_SYNC_CYC;
            end
            `I2CS_A_CTRL2: begin
               reply_action <= wb_dat_i[`I2CS_C2_ACT];
               group_order_en <= wb_dat_i[`I2CS_C2_GROUP_ORDER_EN];
               p_cmd <= wb_dat_i[`I2CS_C2_CMD +: 2];
               p_cmd_v <= 1'b1;
               sync_cnt <= `I2CS_SYNC_CYC;
            end
            `I2CS_A_MCLR: mask <= mask & ~wb_dat_i[2:0];
            `I2CS_A_MSET: mask <= mask | wb_dat_i[2:0];
            `I2CS_A_STAT: begin
               p_bus <= wb_dat_i[`I2CS_ST_BUS +: 2];
               p_bus_v <= 1'b1;
               sync_cnt <= `I2CS_SYNC_CYC;
            end
            `I2CS_A_DATA: txd <= wb_dat_i[7:0];
            default: ;
         endcase
      end
      if (wr && (wb_adr_i == `I2CS_A_ADDR)) begin
         addr_reg <= addr_wr[15:0];
      end
   end
end

// ********************
// Flags and request lines
// ********************
// A set in the same cycle as a clear wins
always @(posedge clk_i) begin
   if (srst) begin
      flags <= 3'h0;
      irq_o <= 1'b0;
      wake_o <= 1'b0;
      core_clk_run_o <= 1'b1;
   end else begin
      flags[`I2CS_F_STOP] <= ev_stop | (flags[`I2CS_F_STOP] &
         ~(wr & (wb_adr_i == `I2CS_A_FLAG) & wm[`I2CS_F_STOP]));
      flags[`I2CS_F_AMATCH] <= ev_amatch | (flags[`I2CS_F_AMATCH] &
         ~(wr & (wb_adr_i == `I2CS_A_FLAG) & wm[`I2CS_F_AMATCH]));
      // Data access or service command also services the byte
      flags[`I2CS_F_DONE] <= ev_done | (flags[`I2CS_F_DONE] &
         ~(wr & (wb_adr_i == `I2CS_A_FLAG) & wm[`I2CS_F_DONE]) &
         ~data_hit & ~svc_now);
      irq_o <= |(flags & mask);
      wake_o <= standby_i & keep & |(flags & mask);
      // Controller clock policy in sleep
      core_clk_run_o <= ~standby_i | keep |
         (ctrlm & (state != S_IDLE));
   end
end

// ********************
// Protocol engine
// ********************
// Samples on SCL rise, drives SDA after SCL fall
always @(posedge clk_i) begin
   if (srst) begin
      state <= S_IDLE;
      nxt <= S_IDLE;
      bitn <= 4'h0;
      sh <= 8'h00;
      rxd <= 8'h00;
      {ten_ok, addressed, dir, refused_byte_flag} <= 4'h0;
      {fast_mode_flag, target_active_flag} <= 2'h0;
      {ev_stop, ev_amatch, ev_done, ev_nack} <= 4'h0;
      {scl_o, scl_oe_o, sda_o, sda_oe_o} <= 4'h0;
   end else begin
      {ev_stop, ev_amatch, ev_done, ev_nack} <= 4'h0;
      if (ev_nack) begin
         refused_byte_flag <= 1'b1;
      end
      if (!en || abort_now) begin
         state <= S_IDLE;
         scl_oe_o <= 1'b0;
         sda_oe_o <= 1'b0;
      end else if (stop_c) begin
         // Only an addressed target reports the STOP
         ev_stop <= addressed;
         state <= S_IDLE;
         fast_mode_flag <= 1'b0;
         {addressed, ten_ok, target_active_flag} <= 3'h0;
         scl_oe_o <= 1'b0;
         sda_oe_o <= 1'b0;
      end else if (start_c) begin
         // Group mode keeps the match across repeated starts
         if (!group_order_en) begin
            addressed <= 1'b0;
         end
         target_active_flag <= 1'b0;
         state <= S_ADDR;
         bitn <= 4'h0;
         sda_oe_o <= 1'b0;
      end else begin
         case (state)
            S_ADDR, S_ADDR2, S_RX: begin
               if (rise && bitn != 4'h8) begin
                  sh <= {sh[6:0], sda_s2};
                  bitn <= bitn + 4'h1;
               end else if (fall && bitn == 4'h8) begin
                  bitn <= 4'h0;
                  state <= S_SKIP;
                  if (state == S_RX) begin
                     rxd <= sh;
                     ev_done <= 1'b1;
                     scl_oe_o <= 1'b1;
                     state <= S_RXW;
                  end else if (state == S_ADDR2) begin
                     if (awake && sh == addr_reg[7:0]) begin
                        ev_amatch <= 1'b1;
                        {ten_ok, addressed, target_active_flag} <= 3'h7;
                        dir <= 1'b0;
                        sda_oe_o <= 1'b1;
                        nxt <= S_RX;
                        state <= S_AACK;
                     end else begin
                        ten_ok <= 1'b0;
                     end
                  end else if (sh[7:3] == `I2CS_MCODE) begin
                     // Controller code is never acknowledged
                     if (spd == `I2CS_SPD_HS && stretch_mode_sel) begin
                        fast_mode_flag <= 1'b1;
                     end
                  end else if (!wide) begin
                     if (awake && sh[7:1] == addr_reg[6:0]) begin
                        ev_amatch <= 1'b1;
                        {addressed, target_active_flag} <= 2'h3;
                        dir <= sh[0];
                        sda_oe_o <= 1'b1;
                        nxt <= sh[0] ? S_TLD : S_RX;
                        state <= S_AACK;
                     end
                  end else if (awake && sh[7:3] == `I2CS_HDR10 &&
                        sh[2:1] == addr_reg[9:8]) begin
                     if (!sh[0]) begin
                        sda_oe_o <= 1'b1;
                        nxt <= S_ADDR2;
                        state <= S_AACK;
                     end else if (ten_ok) begin
                        ev_amatch <= 1'b1;
                        {addressed, target_active_flag} <= 2'h3;
                        dir <= 1'b1;
                        sda_oe_o <= 1'b1;
                        nxt <= S_TLD;
                        state <= S_AACK;
                     end
                  end
               end
            end
            S_AACK: begin
               if (fall) begin
                  sda_oe_o <= 1'b0;
                  bitn <= 4'h0;
                  refused_byte_flag <= 1'b0;
                  if (nxt == S_TLD) begin
                     sh <= txd;
                     sda_oe_o <= ~txd[7];
                     bitn <= 4'h1;
                     state <= S_TX;
                  end else begin
                     state <= nxt;
                  end
               end
            end
            S_RXW: begin
               // Stretch until the byte-done flag is serviced
               if (!flags[`I2CS_F_DONE] && !ev_done) begin
                  // Reply settles first so SDA never moves as SCL rises
                  sda_oe_o <= ~reply_action;
                  state <= S_RACK;
               end
            end
            S_RACK: begin
               // Free SCL one cycle after the reply is on SDA
               if (scl_oe_o) begin
                  scl_oe_o <= 1'b0;
               end else if (fall) begin
                  sda_oe_o <= 1'b0;
                  state <= S_RX;
               end
            end
            S_TX: begin
               if (fall) begin
                  if (bitn == 4'h8) begin
                     sda_oe_o <= 1'b0;
                     state <= S_TACK;
                  end else begin
                     sda_oe_o <= ~sh[6];
                     sh <= {sh[6:0], 1'b0};
                     bitn <= bitn + 4'h1;
                  end
               end
            end
            S_TACK: begin
               if (rise) begin
                  ev_done <= 1'b1;
                  if (sda_s2) begin
                     ev_nack <= 1'b1;
                     state <= S_SKIP;
                  end else begin
                     state <= S_TLD;
                  end
               end
            end
            S_TLD: begin
               if (fall) begin
                  sh <= txd;
                  sda_oe_o <= ~txd[7];
                  bitn <= 4'h1;
                  state <= S_TX;
               end
            end
            S_SKIP: begin
               sda_oe_o <= 1'b0;
               scl_oe_o <= 1'b0;
            end
            default: state <= S_IDLE;
         endcase
      end
   end
end

endmodule
`default_nettype wire

//--- tb/i2cs_chk_sva.sv
// Port checker for the two-wire target engine
`timescale 1ns/1ns
`default_nettype none
module i2cs_chk (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   input wire scl_i,
   input wire sda_i,
   input wire scl_o,
   input wire sda_o,
   input wire scl_oe_o,
   input wire sda_oe_o,
   input wire standby_i,
   input wire irq_o,
   input wire wake_o,
   input wire core_clk_run_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Cycles since the last bus answer, saturating
   logic [3:0] since_ack;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         since_ack <= 4'hF;
      end else if (wb_ack_o) begin
         since_ack <= 4'h0;
      end else if (since_ack != 4'hF) begin
         since_ack <= since_ack + 4'h1;
      end
   end
   property p_ack_next;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("no answer");
   property p_ack_once;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("long ack");
   property p_od;
      !scl_o && !sda_o;
   endproperty
   a_od: assert property (p_od) else $error("line driven high");
   property p_sda_move;
      $changed(sda_oe_o) |-> !scl_i;
   endproperty
   a_sda_move: assert property (p_sda_move) else $error("sda moved");
   property p_stretch_start;
      $rose(scl_oe_o) |-> !scl_i;
   endproperty
   a_stretch_start: assert property (p_stretch_start) else $error("grab");
   // Stretch ends only through a software access
   property p_stretch_end;
      $fell(scl_oe_o) |-> since_ack < 4'h8;
   endproperty
   a_stretch_end: assert property (p_stretch_end) else $error("early");
   property p_stop_idle;
      scl_i && $rose(sda_i) |=> !sda_oe_o [*8];
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("busy");
   property p_reset_quiet;
      $fell(rst_i) |-> !irq_o && !wake_o && core_clk_run_o;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("rst");
   property p_wake;
      wake_o |-> $past(standby_i) && irq_o;
   endproperty
   a_wake: assert property (p_wake) else $error("wake");
   property p_clk_run;
      !$past(standby_i) |-> core_clk_run_o;
   endproperty
   a_clk_run: assert property (p_clk_run) else $error("clock off");
   c_stretch: cover property ($rose(scl_oe_o));
   c_irq: cover property ($rose(irq_o));
   c_wake: cover property ($rose(wake_o));
endmodule
bind i2cs_top i2cs_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .scl_i(scl_i), .sda_i(sda_i), .scl_o(scl_o), .sda_o(sda_o),
   .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o), .standby_i(standby_i),
   .irq_o(irq_o), .wake_o(wake_o), .core_clk_run_o(core_clk_run_o));
`default_nettype wire

//--- tb/i2cs_ctl_model.sv
// Behavioural bus controller facing the target engine
`timescale 1ns/1ns
`default_nettype none
module i2cs_ctl_model (
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_low_o,
   output logic sda_low_o
);
   // Both lines released, pull-ups hold them high
   initial begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
   end
   // One bit: 32 ns low, 16 ns high; SCL low on entry
   task automatic pulse(input logic drv, output logic seen);
      int n;
      n = 0;
      #8 sda_low_o = !drv;
      #24 scl_low_o = 1'b0;
      // Target may stretch; bounded so a stuck line cannot hang
      while (scl_i !== 1'b1 && n < 20000) begin
         #1 n = n + 1;
      end
      #8 seen = sda_i;
      #8 scl_low_o = 1'b1;
   endtask
   // Start or repeated start: SDA falls while SCL high
   task automatic start();
      #8 sda_low_o = 1'b0;
      #8 scl_low_o = 1'b0;
      #16 sda_low_o = 1'b1;
      #16 scl_low_o = 1'b1;
   endtask
   // Stop: SDA rises while SCL high, clock then stands still
   task automatic stop();
      #8 sda_low_o = 1'b1;
      #24 scl_low_o = 1'b0;
      #16 sda_low_o = 1'b0;
      #40;
   endtask
   // Byte out, MSB first, then the target's reply
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         pulse(b[i], s);
      end
      pulse(1'b1, s);
      ack = !s;
      #40;
   endtask
   // Byte in, then our own reply
   task automatic rbyte(input logic nack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         pulse(1'b1, s);
         b[i] = s;
      end
      pulse(nack, s);
      #40;
   endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the two-wire target engine
`timescale 1ns/1ns
`default_nettype none
`include "i2cs_consts.vh"
module tb;
   // ****
   // Signals
   // ****
   localparam logic [7:0] ac1 = `I2CS_A_CTRL1;
   localparam logic [7:0] ac2 = `I2CS_A_CTRL2;
   localparam logic [7:0] aclr = `I2CS_A_MCLR;
   localparam logic [7:0] aset = `I2CS_A_MSET;
   localparam logic [7:0] af = `I2CS_A_FLAG;
   localparam logic [7:0] ast = `I2CS_A_STAT;
   localparam logic [7:0] aad = `I2CS_A_ADDR;
   localparam logic [7:0] ad = `I2CS_A_DATA;
   logic clk, rst, cyc, stb, we, standby, a;
   logic [7:0] adr, d;
   logic [31:0] wdat, q;
   wire [31:0] rdat;
   wire ack, scl_oe, sda_oe, irq, wake, run, m_scl, m_sda, scl_od, sda_od;
   wire scl = !(scl_oe | m_scl); // Open drain with pull-ups
   wire sda = !(sda_oe | m_sda);
   int n_checks, miscompares, cycles;
   i2cs_top dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .scl_i(scl), .scl_o(scl_od),
      .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_od), .sda_oe_o(sda_oe),
      .standby_i(standby), .irq_o(irq), .wake_o(wake), .core_clk_run_o(run));
   i2cs_ctl_model ctl (.scl_i(scl), .sda_i(sda), .scl_low_o(m_scl),
      .sda_low_o(m_sda));
   // ****
   // Helpers
   // ****
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_checks++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Classic cycle; request held until the answer edge
   task automatic bus(input logic w, input logic [7:0] ad_v,
      input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad_v;
      wdat <= wd;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 16);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      chk("answer", ack, 1'b1);
   endtask
   task automatic wr(input logic [7:0] ad_v, input logic [31:0] wd);
      bus(1'b1, ad_v, wd);
   endtask
   // Masked register compare
   task automatic rc(input string nm, input logic [7:0] ad_v,
      input logic [31:0] e, m);
      bus(1'b0, ad_v, 32'h0);
      chk(nm, q & m, e);
   endtask
   // Received byte: software services the stretched clock
   task automatic rx_byte(input logic [7:0] b, input logic e);
      int n;
      fork
         ctl.wbyte(b, a);
         begin
            n = 0;
            do begin
               bus(1'b0, af, 32'h0);
               n++;
            end while (q[2] !== 1'b1 && n < 200);
            chk("stretch", scl_oe, 1'b1);
            rc("rx data", ad, b, 32'hFF);
         end
      join
      chk("reply", a, e);
   endtask
   // ****
   // Scenarios
   // ****
   task automatic s_regs();
      rc("flags", af, 32'h0, 32'hFFFFFFFF);
      chk("irq idle", irq, 1'b0);
      wr(8'h40, 32'hFFFFFFFF);
      rc("unmapped", 8'h40, 32'h0, 32'hFFFFFFFF);
      // Soft reset reads back pending, then clears once synchronised
      wr(ac1, 32'h1);
      rc("soft_reset_bit", ac1, 32'h1, 32'hFF);
      repeat (4) @(posedge clk);
      rc("soft_reset_bit done", ac1, 32'h0, 32'hFF);
   endtask
   task automatic s_rx();
      wr(aad, 32'h2A);
      wr(aset, 32'h7);
      wr(ac1, 32'h2);
      repeat (4) @(posedge clk);
      ctl.start();
      ctl.wbyte(8'h54, a);
      chk("addr ack", a, 1'b1);
      rc("amatch", af, 32'h2, 32'hF);
      chk("irq", irq, 1'b1);
      wr(af, 32'h0);
      rc("flag kept", af, 32'h2, 32'hF);
      wr(af, 32'h2);
      rc("flag clr", af, 32'h0, 32'hF);
      rx_byte(8'hA5, 1'b1);
      wr(ac2, 32'h1);
      rx_byte(8'h5A, 1'b0);
      ctl.stop();
      rc("stop", af, 32'h1, 32'hF);
      wr(aclr, 32'h1);
      rc("stop kept", af, 32'h1, 32'hF);
      chk("masked", irq, 1'b0);
      wr(aset, 32'h1);
      rc("stop again", af, 32'h1, 32'hF);
      chk("unmasked", irq, 1'b1);
      wr(af, 32'h7);
      rc("all clr", af, 32'h0, 32'hF);
      chk("irq off", irq, 1'b0);
      wr(ac2, 32'h0);
   endtask
   task automatic s_group();
      ctl.start();
      ctl.wbyte(8'h20, a);
      chk("other", a, 1'b0);
      ctl.stop();
      rc("no stop", af, 32'h0, 32'hF);
      wr(ac2, 32'h2);
      ctl.start();
      ctl.wbyte(8'h54, a);
      ctl.start();
      ctl.wbyte(8'h20, a);
      ctl.stop();
      rc("group stop", af, 32'h3, 32'hF);
      wr(af, 32'h7);
      wr(ac2, 32'h0);
   endtask
   task automatic s_tx();
      wr(ad, 32'h3C);
      ctl.start();
      ctl.wbyte(8'h55, a);
      ctl.rbyte(1'b1, d);
      chk("tx data", d, 8'h3C);
      rc("refused", ast, 32'h1, 32'h1);
      rc("tx done", af, 32'h4, 32'h4);
      chk("sda free", sda_oe, 1'b0);
      ctl.stop();
      wr(af, 32'h7);
   endtask
   task automatic s_fast();
      wr(ac1, 32'h32);
      repeat (4) @(posedge clk);
      ctl.start();
      ctl.wbyte(8'h09, a);
      chk("code", a, 1'b0);
      rc("fast", ast, 32'h4, 32'h4);
      ctl.stop();
      rc("fast off", ast, 32'h0, 32'h4);
      wr(ac1, 32'h2);
      wr(af, 32'h7);
   endtask
   task automatic s_wide();
      wr(aad, 32'h82A5);
      ctl.start();
      ctl.wbyte(8'hF4, a);
      chk("head", a, 1'b1);
      ctl.wbyte(8'hA5, a);
      rc("wide match", af, 32'h2, 32'h2);
      wr(af, 32'h7);
      ctl.start();
      ctl.wbyte(8'hF5, a);
      chk("read head", a, 1'b1);
      rc("again", af, 32'h2, 32'h2);
      rc("dir", ast, 32'h2, 32'h2);
      ctl.rbyte(1'b1, d);
      ctl.stop();
      wr(af, 32'h7);
      wr(aad, 32'h2A);
   endtask
   task automatic s_sleep();
      standby <= 1'b1;
      ctl.start();
      ctl.wbyte(8'h54, a);
      ctl.stop();
      chk("dropped", a, 1'b0);
      rc("none", af, 32'h0, 32'hF);
      chk("clk off", run, 1'b0);
      wr(ac1, 32'h6);
      repeat (4) @(posedge clk);
      ctl.start();
      ctl.wbyte(8'h54, a);
      rc("kept", af, 32'h2, 32'h2);
      chk("clk kept", run, 1'b1);
      chk("wake", wake, 1'b1);
      ctl.stop();
      wr(af, 32'h7);
      standby <= 1'b0;
   endtask
   // ****
   // Run
   // ****
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = !clk;
   end
   // Hang guard, well above the expected run
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         miscompares++;
         print_verdict();
      end
   end
   initial begin
      {cyc, stb, we, standby, rst} = 5'h01;
      adr = 8'h00;
      wdat = 32'h0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      s_regs();
      s_rx();
      s_group();
      s_tx();
      s_fast();
      s_wide();
      s_sleep();
      print_verdict();
   end
endmodule
`default_nettype wire
